// [logic/tmr_regs.sv]
// Register access part of a 16-bit timer: run control, latch, count, top.
`timescale 1ns/100ps
`include "tmr_params.svh"

// Operation
// RULE_01: A break freezes timer and events unless run_while_halted is 1.
// RULE_02: One shared 8-bit latch at 0x0F serves all 16-bit registers.
// RULE_03: The latch makes a 16-bit access indivisible and resets to zero.
// RULE_04: Software reads and writes the latch directly like any register.
// RULE_05: Count low byte is at 0x20, high byte at 0x21, both reset to zero.
// RULE_06: A count write by software beats a same-cycle hardware update.
// RULE_07: The top value is held at offset 0x26 and resets to all ones.
// RULE_08: Top low byte sits at the base offset, high byte at base plus 0x01.
// RULE_09: Low write fills latch, high write commits; low read latches high.

module tmr_regs
  import tmr_pkg::*;
#(
  parameter int EVT_N = 2
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [7:0]       addr_in,
  input  wire tmr_byte_t        wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output tmr_byte_t             rdata_out,
  input  wire logic             dbg_halt_in,
  input  wire logic             cnt_upd_in,
  input  wire tmr_word_t        cnt_upd_val_in,
  input  wire logic [EVT_N-1:0] evt_in,
  output logic [EVT_N-1:0]      evt_gated_out,
  output logic                  run_out,
  output logic                  run_while_halted_out,
  output tmr_word_t             count_value_out,
  output tmr_word_t             top_value_out
);

  // Address decoder shared by the read and the write paths.
  function automatic tmr_sel_t sel_of(input logic [7:0] a);
    tmr_sel_t s;
    s = tmr_sel_none;
    case (a)
      `TMR_OFS_DBG: begin
        s = tmr_sel_dbg;
      end
      `TMR_OFS_LATCH: begin
        s = tmr_sel_latch;  // [RULE_02]
      end
      `TMR_OFS_CNT: begin
        s = tmr_sel_cnt_lo;  // [RULE_05]
      end
      `TMR_OFS_CNT_HI: begin
        s = tmr_sel_cnt_hi;  // [RULE_05]
      end
      `TMR_OFS_TOP: begin
        s = tmr_sel_top_lo;  // [RULE_07] [RULE_08]
      end
      `TMR_OFS_TOP_HI: begin
        s = tmr_sel_top_hi;  // [RULE_08]
      end
      default: begin
        s = tmr_sel_none;
      end
    endcase
    return s;
  endfunction

  // Register state.
  logic             run_while_halted_ff;
  logic             nxt_run_while_halted;
  tmr_byte_t        latch_ff;
  tmr_byte_t        nxt_latch;
  tmr_byte_t        rdata_ff;
  tmr_byte_t        nxt_rdata;
  logic             run_ff;
  logic [EVT_N-1:0] evt_ff;

  // Decoded access.
  tmr_sel_t         sel;
  logic             wr_dbg;
  logic             wr_latch;
  logic             wr_cnt_lo;
  logic             wr_cnt_hi;
  logic             wr_top_lo;
  logic             wr_top_hi;
  logic             rd_cnt_lo;
  logic             rd_top_lo;

  // Run control.
  logic             running;
  logic             halted_now;
  logic             cnt_upd_ok;
  logic [EVT_N-1:0] nxt_evt;

  // Current 16-bit values and the debug readback byte.
  tmr_word_t        cnt_val;
  tmr_word_t        top_val;
  tmr_byte_t        dbg_rd;

  // One decode serves both strobes; the master never raises them together.
  assign sel = sel_of(addr_in);

  // Write strobes per register.
  assign wr_dbg    = wr_in && (sel == tmr_sel_dbg);
  assign wr_latch  = wr_in && (sel == tmr_sel_latch);
  assign wr_cnt_lo = wr_in && (sel == tmr_sel_cnt_lo);
  assign wr_cnt_hi = wr_in && (sel == tmr_sel_cnt_hi);
  assign wr_top_lo = wr_in && (sel == tmr_sel_top_lo);
  assign wr_top_hi = wr_in && (sel == tmr_sel_top_hi);

  // Low byte reads have the side effect of loading the latch.
  assign rd_cnt_lo = rd_in && (sel == tmr_sel_cnt_lo);
  assign rd_top_lo = rd_in && (sel == tmr_sel_top_lo);

  // The timer runs unless the core is in a debug break and the run bit
  // is clear. The halt input comes from the debug logic on this clock.
  assign halted_now = dbg_halt_in;
  assign running    = !halted_now || run_while_halted_ff;  // [RULE_01]

  // Hardware count steps are dropped while the timer is frozen, so the
  // value seen by the debugger stays put during the break.
  assign cnt_upd_ok = cnt_upd_in && running;  // [RULE_01]

  // Run bit write path.
  assign nxt_run_while_halted = wr_dbg ? wdata_in[`TMR_BIT_RUN]
                                       : run_while_halted_ff;

  // Latch sources: a direct write, a low byte write that parks the byte
  // until the high byte commits, or a low byte read that snapshots the
  // high byte so a following high read sees the same 16-bit sample.
  assign nxt_latch = wr_latch  ? wdata_in :            // [RULE_04]
                     wr_cnt_lo ? wdata_in :            // [RULE_09]
                     wr_top_lo ? wdata_in :            // [RULE_09]
                     rd_cnt_lo ? cnt_val[15:8] :       // [RULE_03]
                     rd_top_lo ? top_val[15:8] :       // [RULE_03]
                     latch_ff;

  // Debug register readback: the run bit plus the live halt state.
  always_comb begin
    dbg_rd = 8'h00;
    dbg_rd[`TMR_BIT_RUN]    = run_while_halted_ff;
    dbg_rd[`TMR_BIT_HALTED] = halted_now;
  end

  // Read multiplexer. A high byte read returns the latch, which holds the
  // byte captured by the preceding low byte read; unmapped reads give 0.
  always_comb begin
    nxt_rdata = 8'h00;
    case (sel)
      tmr_sel_dbg: begin
        nxt_rdata = dbg_rd;
      end
      tmr_sel_latch: begin
        nxt_rdata = latch_ff;  // [RULE_04]
      end
      tmr_sel_cnt_lo: begin
        nxt_rdata = cnt_val[7:0];  // [RULE_09]
      end
      tmr_sel_cnt_hi: begin
        nxt_rdata = latch_ff;  // [RULE_09] [RULE_03]
      end
      tmr_sel_top_lo: begin
        nxt_rdata = top_val[7:0];  // [RULE_09]
      end
      tmr_sel_top_hi: begin
        nxt_rdata = latch_ff;  // [RULE_09] [RULE_03]
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // Incoming events pass only while the timer runs.
  genvar gi;
  generate
    for (gi = 0; gi < EVT_N; gi++) begin : g_evt
      assign nxt_evt[gi] = evt_in[gi] && running;  // [RULE_01]
    end
  endgenerate

  // Run bit.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      run_while_halted_ff <= `TMR_RST_DBG;
    end else begin
      run_while_halted_ff <= nxt_run_while_halted;
    end
  end

  // The single shared latch.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      latch_ff <= `TMR_RST_LATCH;  // [RULE_02] [RULE_03]
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // Read data is held for exactly the cycle after the read strobe.
  // Clearing it outside that cycle keeps a stale byte from looking like
  // a fresh answer to a master that samples one cycle too late.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rdata_ff <= `TMR_RST_RDATA;
    end else if (rd_in) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= `TMR_RST_RDATA;
    end
  end

  // Registered run state and gated events.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      run_ff <= 1'b0;
      evt_ff <= '0;
    end else begin
      run_ff <= running;
      evt_ff <= nxt_evt;
    end
  end

  // Count value; a high byte write commits it together with the latch.
  tmr_byte_pair #(
    .RST_VAL (`TMR_RST_CNT)
  ) u_count (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .commit_in (wr_cnt_hi),
    .wdata_in  (wdata_in),
    .latch_in  (latch_ff),
    .hw_upd_in (cnt_upd_ok),
    .hw_val_in (cnt_upd_val_in),
    .value_out (cnt_val)
  );

  // Top value; only software changes it here.
  tmr_byte_pair #(
    .RST_VAL (`TMR_RST_TOP)
  ) u_top (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .commit_in (wr_top_hi),
    .wdata_in  (wdata_in),
    .latch_in  (latch_ff),
    .hw_upd_in (1'b0),
    .hw_val_in (16'h0000),
    .value_out (top_val)
  );

  // Outputs. Run and events lag the halt input by one cycle.
  assign rdata_out            = rdata_ff;
  assign evt_gated_out        = evt_ff;
  assign run_out              = run_ff;
  assign run_while_halted_out = run_while_halted_ff;
  assign count_value_out      = cnt_val;
  assign top_value_out        = top_val;

endmodule

// [include/tmr_params.svh]
// Offsets, field positions and reset values of the timer register block.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// Byte offsets on the register port.
`define TMR_OFS_DBG      8'h0E
`define TMR_OFS_LATCH    8'h0F
`define TMR_OFS_CNT      8'h20
`define TMR_OFS_TOP      8'h26
`define TMR_OFS_HI       8'h01
`define TMR_OFS_CNT_HI   (`TMR_OFS_CNT + `TMR_OFS_HI)
`define TMR_OFS_TOP_HI   (`TMR_OFS_TOP + `TMR_OFS_HI)

// Field positions in the debug control register.
`define TMR_BIT_RUN      0
`define TMR_BIT_HALTED   1

// Reset values.
`define TMR_RST_DBG      1'b0
`define TMR_RST_LATCH    8'h00
`define TMR_RST_CNT      16'h0000
`define TMR_RST_TOP      16'hFFFF
`define TMR_RST_RDATA    8'h00

`endif

// [include/tmr_pkg.sv]
// Types shared by the timer register block modules.
package tmr_pkg;

  typedef logic [7:0]  tmr_byte_t;
  typedef logic [15:0] tmr_word_t;

  // Which register a bus address selects.
  typedef enum logic [2:0] {
    tmr_sel_none   = 3'b000,
    tmr_sel_dbg    = 3'b001,
    tmr_sel_latch  = 3'b010,
    tmr_sel_cnt_lo = 3'b011,
    tmr_sel_cnt_hi = 3'b100,
    tmr_sel_top_lo = 3'b101,
    tmr_sel_top_hi = 3'b110
  } tmr_sel_t;

endpackage

// [logic/tmr_byte_pair.sv]
// One 16-bit timer register with byte-pair commit and a hardware update port.
`timescale 1ns/100ps

module tmr_byte_pair
  import tmr_pkg::*;
#(
  parameter tmr_word_t RST_VAL = 16'h0000
) (
  input  wire logic      clk_in,
  input  wire logic      resetn_in,
  input  wire logic      commit_in,
  input  wire tmr_byte_t wdata_in,
  input  wire tmr_byte_t latch_in,
  input  wire logic      hw_upd_in,
  input  wire tmr_word_t hw_val_in,
  output tmr_word_t      value_out
);

  tmr_word_t value_ff;
  tmr_word_t nxt_value;
  tmr_word_t bus_word;

  // The high byte comes from the bus, the low byte from the shared latch.
  assign bus_word = {wdata_in, latch_in};

  // A software commit beats a hardware update in the same cycle, so the
  // written value is never overwritten by a stale count step.
  assign nxt_value = commit_in ? bus_word :  // [RULE_06] [RULE_09]
                     hw_upd_in ? hw_val_in :
                     value_ff;

  // Register holding the 16-bit value.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      value_ff <= RST_VAL;  // [RULE_05] [RULE_07]
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value_out = value_ff;

endmodule

// [sim/tmr_regs_asserts.sv]
// Port checks for the timer register block, bound to its top module.
`timescale 1ns/100ps

module tmr_regs_chk
  import tmr_pkg::*;
#(
  parameter int EVT_N = 2
) (
  input wire logic             clk_in,
  input wire logic             resetn_in,
  input wire logic [7:0]       addr_in,
  input wire tmr_byte_t        wdata_in,
  input wire logic             wr_in,
  input wire logic             rd_in,
  input wire tmr_byte_t        rdata_out,
  input wire logic             dbg_halt_in,
  input wire logic             cnt_upd_in,
  input wire tmr_word_t        cnt_upd_val_in,
  input wire logic [EVT_N-1:0] evt_in,
  input wire logic [EVT_N-1:0] evt_gated_out,
  input wire logic             run_out,
  input wire logic             run_while_halted_out,
  input wire tmr_word_t        count_value_out,
  input wire tmr_word_t        top_value_out
);
  // The timer moves unless a break freezes it.
  wire go = !dbg_halt_in || run_while_halted_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_reset_vals: assert property (disable iff (1'b0)
    !resetn_in |=> top_value_out == 16'hFFFF && count_value_out == 16'h0000)
    else $error("reset values wrong");
  a_top_read: assert property (
    rd_in && addr_in == 8'h26 |=> rdata_out == $past(top_value_out[7:0]))
    else $error("top low byte read wrong");
  a_pair_read: assert property (
    rd_in && addr_in == 8'h20 ##1 !(wr_in || rd_in) ##1
    rd_in && addr_in == 8'h21
    |=> rdata_out == $past(count_value_out[15:8], 3))
    else $error("high byte not from the low byte snapshot");
  a_low_hold: assert property (
    wr_in && addr_in == 8'h20 && !cnt_upd_in |=> $stable(count_value_out))
    else $error("low byte write changed the count");
  a_high_commit: assert property (
    wr_in && addr_in == 8'h20 ##1 !(wr_in || rd_in) ##1
    wr_in && addr_in == 8'h21
    |=> count_value_out == {$past(wdata_in), $past(wdata_in, 3)})
    else $error("16-bit count write not committed");
  a_write_wins: assert property (
    wr_in && addr_in == 8'h21 && cnt_upd_in
    |=> count_value_out[15:8] == $past(wdata_in))
    else $error("hardware update beat a write");
  a_frozen_upd: assert property (
    !go && cnt_upd_in && !wr_in |=> $stable(count_value_out))
    else $error("count moved in a break");
  a_run_follow: assert property (
    !wr_in |=> run_out == $past(go) &&
    evt_gated_out == ($past(evt_in) & {EVT_N{$past(go)}}))
    else $error("run or event gating wrong");

  c_wins: cover property (wr_in && addr_in == 8'h21 && cnt_upd_in);
  c_frozen: cover property (!go && cnt_upd_in);
  c_latch: cover property (rd_in && addr_in == 8'h0F);
endmodule

bind tmr_regs tmr_regs_chk #(.EVT_N(EVT_N)) u_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .dbg_halt_in(dbg_halt_in),
  .cnt_upd_in(cnt_upd_in), .cnt_upd_val_in(cnt_upd_val_in),
  .evt_in(evt_in), .evt_gated_out(evt_gated_out), .run_out(run_out),
  .run_while_halted_out(run_while_halted_out),
  .count_value_out(count_value_out), .top_value_out(top_value_out)
);

// [sim/tmr_core_model.sv]
// Bus master standing in for the processor core and the debug port.
`timescale 1ns/100ps

module tmr_core_model
  import tmr_pkg::*;
(
  input  wire logic      clk_in,
  input  wire tmr_byte_t rdata_in,
  output logic [7:0]     addr_out,
  output tmr_byte_t      wdata_out,
  output logic           wr_out,
  output logic           rd_out
);
  // Bus idle at time zero.
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // Data is inverted after release so nothing stale looks valid. The task
  // returns mid-cycle, so a caller sees the written register settled.
  task automatic wr_b(input logic [7:0] a, input tmr_byte_t d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
    @(negedge clk_in);
  endtask

  // The answer stands one cycle only, so it is taken in the middle of it.
  task automatic rd_b(input logic [7:0] a, output tmr_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(negedge clk_in);
    d = rdata_in;
  endtask

  // A word goes low byte first so the high byte commits both.
  task automatic wr16(input logic [7:0] a, input tmr_word_t v);
    wr_b(a, v[7:0]);
    wr_b(a + 8'h01, v[15:8]);
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the timer register block.
`timescale 1ns/100ps

module tb
  import tmr_pkg::*;
;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic [7:0] addr;
  tmr_byte_t  wdata;
  logic       wr;
  logic       rd;
  tmr_byte_t  rdata;
  logic       dbg_halt_in = 1'b0;
  logic       cnt_upd_in = 1'b0;
  tmr_word_t  cnt_upd_val_in = 16'h0000;
  logic [1:0] evt_in = 2'h0;
  logic [1:0] evt_gated;
  logic       run;
  tmr_word_t  count;
  tmr_word_t  top;
  logic       rwh;
  tmr_byte_t  b;
  int         bad_count = 0;
  int         compares = 0;

  always #5 clk_in = ~clk_in;

  tmr_regs u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .dbg_halt_in(dbg_halt_in), .cnt_upd_in(cnt_upd_in),
    .cnt_upd_val_in(cnt_upd_val_in), .evt_in(evt_in),
    .evt_gated_out(evt_gated), .run_out(run), .run_while_halted_out(rwh),
    .count_value_out(count), .top_value_out(top));
  tmr_core_model u_core (.clk_in(clk_in), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  // Case equality so an unknown never counts as a match.
  task automatic chk8(input tmr_byte_t got, input tmr_byte_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input tmr_word_t got, input tmr_word_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One-cycle hardware count update, checked after its edge has landed.
  task automatic upd(input tmr_word_t v);
    @(posedge clk_in);
    cnt_upd_in     <= 1'b1;
    cnt_upd_val_in <= v;
    @(posedge clk_in);
    cnt_upd_in <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    u_core.rd_b(8'h20, b);
    chk8(b, 8'h00);
    u_core.rd_b(8'h21, b);
    chk8(b, 8'h00);
    u_core.rd_b(8'h0F, b);
    chk8(b, 8'h00);
    u_core.rd_b(8'h30, b);
    chk8(b, 8'h00);
    chk16(top, 16'hFFFF);
  endtask

  // One latch serves both registers.
  task automatic t_latch;
    u_core.wr_b(8'h0F, 8'hA5);
    u_core.rd_b(8'h0F, b);
    chk8(b, 8'hA5);
    u_core.wr_b(8'h27, 8'h12);
    chk16(top, 16'h12A5);
    u_core.wr_b(8'h0F, 8'h5A);
    u_core.wr_b(8'h21, 8'h34);
    chk16(count, 16'h345A);
  endtask

  task automatic t_pair;
    u_core.wr_b(8'h20, 8'h34);
    chk16(count, 16'h345A);
    u_core.wr_b(8'h21, 8'h12);
    chk16(count, 16'h1234);
    u_core.wr16(8'h26, 16'hBEEF);
    u_core.rd_b(8'h26, b);
    chk8(b, 8'hEF);
    u_core.rd_b(8'h27, b);
    chk8(b, 8'hBE);
  endtask

  // A hardware carry between the two reads must not tear the word.
  task automatic t_snap;
    u_core.wr16(8'h20, 16'h12FF);
    u_core.rd_b(8'h20, b);
    chk8(b, 8'hFF);
    upd(16'h1300);
    u_core.rd_b(8'h21, b);
    chk8(b, 8'h12);
    chk16(count, 16'h1300);
  endtask

  task automatic t_wins;
    fork
      u_core.wr_b(8'h21, 8'h77);
      upd(16'hABCD);
    join
    chk16(count, 16'h7712);
  endtask

  // Break freezes updates and events until the run bit is set.
  task automatic t_debug;
    @(posedge clk_in);
    dbg_halt_in <= 1'b1;
    evt_in      <= 2'h3;
    upd(16'h4444);
    chk16(count, 16'h7712);
    chk8({6'h00, evt_gated}, 8'h00);
    chk8({7'h00, run}, 8'h00);
    u_core.rd_b(8'h0E, b);
    chk8(b, 8'h02);
    u_core.wr_b(8'h0E, 8'h01);
    chk8({7'h00, rwh}, 8'h01);
    u_core.rd_b(8'h0E, b);
    chk8(b, 8'h03);
    upd(16'h4444);
    chk16(count, 16'h4444);
    chk8({6'h00, evt_gated}, 8'h03);
    chk8({7'h00, run}, 8'h01);
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset;
    t_latch;
    t_pair;
    t_snap;
    t_wins;
    t_debug;
    close_out;
  end

  // The tests need well under 2 us; a hang ends the run as a failure.
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule
